// File: rtl/clkgen_pkg.sv
// constants and carrier types for the clock generator control block
package clkgen_pkg;
    // register offsets
    localparam logic [2:0] OFF_CTRL   = 3'h0;
    localparam logic [2:0] OFF_BW     = 3'h1;
    localparam logic [2:0] OFF_PROG   = 3'h2;
    localparam logic [2:0] OFF_STATUS = 3'h3;
    // control register bit positions
    localparam int BIT_IRQ_EN  = 7;
    localparam int BIT_LOOP_ON = 5;
    localparam int BIT_BASE_SEL = 4;
    // bandwidth register bit positions
    localparam int BIT_AUTO    = 7;
    localparam int BIT_LOCK    = 6;
    localparam int BIT_ACQ     = 5;
    // status register bit positions
    localparam int BIT_LOCK_CHG = 0;
    localparam int BIT_VCO_USED = 1;
    localparam int BIT_SWITCHING = 2;
    // values after reset
    localparam logic [7:0] RST_PROG = 8'h10;
    localparam logic       RST_AUTO = 1'b0;
    // cycle counts
    localparam logic [1:0] SWITCH_EDGES = 2'h3;
    localparam int         LOCK_WINDOW  = 8;
    localparam int         TRK_TOL      = 0;
    localparam int         UNT_TOL      = 1;
    localparam int         LOCK_TOL     = 0;
    localparam int         UNL_TOL      = 1;
    // nominal centre frequency in hz
    localparam logic [31:0] F_NOM_HZ = 32'h004b_0000;
    // programming register layout
    typedef struct packed {
        logic [3:0] mult_n;  // feedback divide factor
        logic [3:0] mult_l;  // vco range factor
    } prog_t;
    // base clock selector states
    typedef enum logic [1:0] {
        SEL_RUN  = 2'b00,
        SEL_HOLD = 2'b01
    } sel_state_t;
endpackage : clkgen_pkg

// File: rtl/pll_clock_generator_control.sv
// digital control of the crystal/vco base clock generator
module pll_clock_generator_control
    import clkgen_pkg::*;
#(
    parameter int DIV_W = 4  // feedback divider counter width
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_crystal_amp_input,
    input  wire logic        i_vco_clock,
    input  wire logic        i_oscillator_enable_in,
    input  wire logic [2:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    output logic             o_crystal_amp_output,
    output logic             o_crystal_clock_out,
    output logic             o_base_clock_out,
    output logic             o_pump_up,
    output logic             o_pump_down,
    output logic             o_track_mode,
    output logic [31:0]      o_vco_centre_hz,
    output logic             o_clockgen_cpu_irq
);
    // synchroniser stages for the two outside clocks
    logic [2:0] xtal_sync;        // crystal pin sampled
    logic [2:0] vco_sync;         // vco clock sampled
    logic       osc_en;           // registered oscillator enable
    logic       xtal_edge;        // rising crystal edge, gated
    logic       vco_edge;         // rising vco edge, gated
    // software state
    logic       irq_en;           // lock-change interrupt enable
    logic       loop_power_on;    // loop power request
    logic       base_source_select; // vco requested as source
    logic       auto_mode;        // automatic bandwidth control
    logic       acq_manual;       // acquire/track bit in manual mode
    prog_t      prog;             // n and l factors
    logic       lock_chg;         // sticky lock-change flag
    // loop state
    logic       loop_enabled;     // power on with l nonzero
    logic       vco_wanted;       // effective requested source
    logic       vco_active;       // source currently driving base
    sel_state_t sel_state;        // selector state
    logic [1:0] xtal_cnt;         // crystal edges seen while holding
    logic [1:0] vco_cnt;          // vco edges seen while holding
    logic [DIV_W-1:0] div_cnt;    // feedback divider count
    logic [DIV_W-1:0] div_last;   // terminal count of divider
    logic       fb_edge;          // feedback clock edge
    logic [4:0] win_cnt;          // reference edges in window
    logic [4:0] fb_cnt;           // feedback edges in window
    logic       lock;             // lock indication
    logic       acq_auto;         // detector tracking decision
    logic       acquire_track_bit; // visible mode bit
    logic       lock_prev;        // lock one cycle earlier
    logic       lock_change;      // lock toggled this cycle
    logic       wr_ctrl;          // write to control register
    logic [5:0] diff_abs;         // window count difference
    logic [5:0] fb_total;         // feedback edges, this cycle included
    logic [5:0] ref_total;        // reference edges, this one included

    // crystal runs only while the enable is held
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            osc_en <= 1'b0;
        end else begin
            osc_en <= i_oscillator_enable_in;
        end
    end

    // two-flop synchronisers plus an edge stage; duty cycle not assumed
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            xtal_sync <= 3'h0;
            vco_sync  <= 3'h0;
        end else begin
            xtal_sync <= {xtal_sync[1:0], i_crystal_amp_input};
            vco_sync  <= {vco_sync[1:0], i_vco_clock};
        end
    end

    // edges only from the second and third stages
    assign xtal_edge = osc_en && xtal_sync[1] && !xtal_sync[2];
    assign vco_edge  = loop_enabled && vco_sync[1] && !vco_sync[2];

    // crystal clock out and inverting amplifier output
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_crystal_clock_out  <= 1'b0;
            o_crystal_amp_output <= 1'b0;
        end else begin
            o_crystal_clock_out  <= osc_en && xtal_sync[1];
            o_crystal_amp_output <= osc_en && !xtal_sync[1];
        end
    end

    // loop only runs with power on and l nonzero
    assign loop_enabled = loop_power_on && (prog.mult_l != 4'h0);
    assign vco_wanted   = base_source_select && loop_enabled;

    // centre of range frequency
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_vco_centre_hz <= 32'h0000_0000;
        end else begin
            o_vco_centre_hz <= 32'(F_NOM_HZ * prog.mult_l);
        end
    end

    // modulo n feedback divider, n of zero behaves as one
    assign div_last = (prog.mult_n == 4'h0) ? DIV_W'(0) : DIV_W'(prog.mult_n - 4'h1);
    assign fb_edge  = vco_edge && (div_cnt == div_last);

    always_ff @(posedge i_clk) begin
        if (i_rst || !loop_enabled) begin
            div_cnt <= '0;
        end else if (div_cnt > div_last) begin
            div_cnt <= '0;
        end else if (vco_edge) begin
            div_cnt <= (div_cnt >= div_last) ? '0 : div_cnt + DIV_W'(1);
        end
    end

    // phase detector: reference leads gives up, feedback leads gives down
    always_ff @(posedge i_clk) begin
        if (i_rst || !loop_enabled) begin
            o_pump_up   <= 1'b0;
            o_pump_down <= 1'b0;
        end else if ((o_pump_up || xtal_edge) && (o_pump_down || fb_edge)) begin
            o_pump_up   <= 1'b0;
            o_pump_down <= 1'b0;
        end else begin
            o_pump_up   <= o_pump_up || xtal_edge;
            o_pump_down <= o_pump_down || fb_edge;
        end
    end

    // frequency window: count feedback edges over reference edges
    // both counts cover the same half-open window ending at this reference edge
    assign fb_total  = {1'b0, fb_cnt} + (fb_edge ? 6'h01 : 6'h00);
    assign ref_total = {1'b0, win_cnt} + 6'h01;
    assign diff_abs  = (fb_total > ref_total) ? (fb_total - ref_total) : (ref_total - fb_total);

    always_ff @(posedge i_clk) begin
        if (i_rst || !loop_enabled) begin
            win_cnt <= 5'h00;
            fb_cnt  <= 5'h00;
        end else if (xtal_edge && (win_cnt == 5'(LOCK_WINDOW - 1))) begin
            win_cnt <= 5'h00;
            fb_cnt  <= 5'h00; // this edge already counted in the closing window
        end else begin
            win_cnt <= win_cnt + (xtal_edge ? 5'h01 : 5'h00);
            fb_cnt  <= (fb_cnt == 5'h1f) ? fb_cnt : fb_cnt + (fb_edge ? 5'h01 : 5'h00);
        end
    end

    // lock decided once per window, mode too except that an active vco source forces track at once; hysteresis between limits
    always_ff @(posedge i_clk) begin
        if (i_rst || !loop_enabled || !auto_mode) begin
            lock     <= 1'b0;
            acq_auto <= 1'b0;
        end else if (xtal_edge && (win_cnt == 5'(LOCK_WINDOW - 1))) begin
            if (diff_abs <= 6'(LOCK_TOL)) begin
                lock <= 1'b1;
            end else if (diff_abs > 6'(UNL_TOL)) begin
                lock <= 1'b0;
            end
            if (diff_abs <= 6'(TRK_TOL) || vco_active) begin
                acq_auto <= 1'b1;
            end else if (diff_abs > 6'(UNT_TOL)) begin
                acq_auto <= 1'b0;
            end
        end else if (vco_active) begin
            acq_auto <= 1'b1;
        end
    end

    // mode bit: detector in auto, software in manual
    assign acquire_track_bit = auto_mode ? acq_auto : acq_manual;

    // track mode follows the bit while the loop runs, low with the loop off; clear means acquisition
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_track_mode <= 1'b0;
        end else begin
            o_track_mode <= loop_enabled && acquire_track_bit;
        end
    end

    // control register, with source/power interlocks
    assign wr_ctrl = i_wr && (i_addr == OFF_CTRL);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_en             <= 1'b0;
            loop_power_on      <= 1'b0;
            base_source_select <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                irq_en <= i_wdata[BIT_IRQ_EN];
                if (i_wdata[BIT_LOOP_ON] != loop_power_on && i_wdata[BIT_BASE_SEL] != base_source_select) begin
                    loop_power_on <= loop_power_on;
                end else if (i_wdata[BIT_BASE_SEL] && !(loop_power_on && prog.mult_l != 4'h0)) begin
                    loop_power_on <= i_wdata[BIT_LOOP_ON];
                end else if (!i_wdata[BIT_LOOP_ON] && base_source_select) begin
                    base_source_select <= i_wdata[BIT_BASE_SEL];
                end else begin
                    loop_power_on      <= i_wdata[BIT_LOOP_ON];
                    base_source_select <= i_wdata[BIT_BASE_SEL];
                end
            end
            // a zero l overrides any select write in the same cycle
            if (prog.mult_l == 4'h0) begin
                base_source_select <= 1'b0;
            end
        end
    end

    // bandwidth and programming registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            auto_mode  <= RST_AUTO;
            acq_manual <= 1'b0;
            prog       <= prog_t'(RST_PROG);
        end else if (i_wr && i_addr == OFF_BW) begin
            auto_mode  <= i_wdata[BIT_AUTO];
            acq_manual <= i_wdata[BIT_ACQ];
        end else if (i_wr && i_addr == OFF_PROG) begin
            prog <= prog_t'(i_wdata);
        end
    end

    // base selector: hold output while three edges of each clock pass, only three crystal edges with the loop off
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sel_state  <= SEL_RUN;
            vco_active <= 1'b0;
            xtal_cnt   <= 2'h0;
            vco_cnt    <= 2'h0;
        end else begin
            case (sel_state)
                SEL_RUN: begin
                    xtal_cnt <= 2'h0;
                    vco_cnt  <= 2'h0;
                    if (vco_wanted != vco_active) begin
                        sel_state <= SEL_HOLD;
                    end
                end
                SEL_HOLD: begin
                    if (xtal_edge && xtal_cnt != SWITCH_EDGES) begin
                        xtal_cnt <= xtal_cnt + 2'h1;
                    end
                    if (vco_edge && vco_cnt != SWITCH_EDGES) begin
                        vco_cnt <= vco_cnt + 2'h1;
                    end
                    if (xtal_cnt == SWITCH_EDGES && (vco_cnt == SWITCH_EDGES || !loop_enabled)) begin
                        vco_active <= vco_wanted;
                        sel_state  <= SEL_RUN;
                    end
                end
                default: begin
                    sel_state <= SEL_RUN;
                end
            endcase
        end
    end

    // halve the chosen source; static while switching
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_base_clock_out <= 1'b0;
        end else if (sel_state == SEL_RUN && (vco_active ? vco_edge : xtal_edge)) begin
            o_base_clock_out <= !o_base_clock_out;
        end
    end

    // lock change flag; a toggle beats a software clear
    assign lock_change = lock != lock_prev;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lock_prev <= 1'b0;
            lock_chg  <= 1'b0;
        end else begin
            lock_prev <= lock;
            if (lock_change && auto_mode) begin
                lock_chg <= 1'b1;
            end else if (i_wr && i_addr == OFF_STATUS && i_wdata[BIT_LOCK_CHG]) begin
                lock_chg <= 1'b0;
            end
        end
    end

    // interrupt request, only in automatic mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_clockgen_cpu_irq <= 1'b0;
        end else begin
            o_clockgen_cpu_irq <= lock_chg && irq_en && auto_mode;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 8'h00;
        end else begin
            case (i_addr)
                OFF_CTRL:   o_rdata <= {irq_en, 1'b0, loop_power_on, base_source_select, 4'h0};
                OFF_BW:     o_rdata <= {auto_mode, lock, acquire_track_bit, 5'h00};
                OFF_PROG:   o_rdata <= prog;
                OFF_STATUS: o_rdata <= {5'h00, sel_state == SEL_HOLD, vco_active, lock_chg};
                default:    o_rdata <= 8'h00;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_vco_needs_loop: assert property (vco_active && !loop_enabled |-> sel_state == SEL_HOLD || $past(loop_enabled))
        else $error("vco source active with loop off");
    a_l_zero_forces: assert property ((prog.mult_l == 4'h0) |=> !base_source_select)
        else $error("l zero did not force crystal");
    a_base_static_hold: assert property ((sel_state == SEL_HOLD) |=> $stable(o_base_clock_out))
        else $error("base clock moved while switching");
    a_crystal_gated: assert property (!osc_en |=> !o_crystal_clock_out)
        else $error("crystal clock ran while disabled");
    a_fb_period: assert property (vco_edge && prog.mult_n == 4'h0 && !$changed(prog) |-> fb_edge)
        else $error("divide by one missed an edge");
    a_pump_exclusive: assert property (!(o_pump_up && o_pump_down))
        else $error("both pump pulses high");
    a_irq_on_toggle: assert property (lock_change && auto_mode && irq_en |=> ##1 o_clockgen_cpu_irq)
        else $error("lock change raised no interrupt");
    a_acq_clear: assert property (!acquire_track_bit |=> !o_track_mode)
        else $error("track mode shown while acquiring");
    a_ctrl_refuse: assert property (wr_ctrl && base_source_select && !i_wdata[BIT_LOOP_ON] |=> loop_power_on)
        else $error("loop turned off while vco selected");
    a_div_range: assert property (div_cnt <= div_last || $changed(prog))
        else $error("divider count out of range");

    c_switch_to_vco: cover property (!vco_active ##1 vco_active);
    c_lock_gained: cover property (!lock ##1 lock);
    c_lock_lost: cover property (lock ##1 !lock);
    c_refused_write: cover property (wr_ctrl && i_wdata[BIT_BASE_SEL] && !loop_enabled);
endmodule : pll_clock_generator_control

// File: test/sim_unit_model.sv
// far-side model: crystal and vco sources, enable source, base clock consumer
module sim_unit_model (
    input  wire logic i_clk,
    input  wire logic i_osc_request,
    input  wire logic [31:0] i_vco_half,
    input  wire logic i_base_clock_out,
    output logic      o_crystal_level,
    output logic      o_vco_level,
    output logic      o_oscillator_enable,
    output int        o_base_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    int   xcnt;   // crystal phase counter
    int   vcnt;   // vco phase counter
    logic base_q; // last base level seen
    initial begin
        {o_crystal_level, o_vco_level, o_oscillator_enable, base_q} = 4'h0;
        {xcnt, vcnt, o_base_edges} = '0;
    end
    // crystal with uneven phases, 9 high and 11 low, so period 20
    always @(posedge i_clk) begin
        xcnt <= xcnt + 1;
        if (xcnt >= (o_crystal_level ? 8 : 10)) begin
            xcnt            <= 0;
            o_crystal_level <= ~o_crystal_level;
        end
    end
    // vco at the half period the bench asks for
    always @(posedge i_clk) begin
        vcnt <= vcnt + 1;
        if (vcnt >= i_vco_half - 1) begin
            vcnt        <= 0;
            o_vco_level <= ~o_vco_level;
        end
    end
    // enable registered as the integration unit does it
    always @(posedge i_clk) o_oscillator_enable <= i_osc_request;
    // counts base clock rising edges, the clocks derived downstream
    always @(posedge i_clk) begin
        base_q <= i_base_clock_out;
        if (i_base_clock_out && !base_q) o_base_edges <= o_base_edges + 1;
    end
endmodule : sim_unit_model

// File: test/pll_clock_generator_control_bench.sv
// self-checking bench for the clock generator control block
module pll_clock_generator_control_bench;
    import clkgen_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst, i_wr, i_rd, osc_req;    // bench-driven
    logic [2:0]  i_addr;                                // register address
    logic [7:0]  i_wdata, rdata;                        // bus data
    logic        xtal, vco, osc_en, amp_out, xclk_out;  // clock pins
    logic        base, up, dn, trk, irq;                // block outputs
    logic [31:0] centre;                                // vco centre
    int          vco_half, base_edges, bad_count, n_compared, cycles;

    pll_clock_generator_control pll_clock_generator_control_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_crystal_amp_input(xtal), .i_vco_clock(vco),
        .i_oscillator_enable_in(osc_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(rdata), .o_crystal_amp_output(amp_out), .o_crystal_clock_out(xclk_out),
        .o_base_clock_out(base), .o_pump_up(up), .o_pump_down(dn), .o_track_mode(trk),
        .o_vco_centre_hz(centre), .o_clockgen_cpu_irq(irq));
    sim_unit_model sim_unit_model_inst (
        .i_clk(i_clk), .i_osc_request(osc_req), .i_vco_half(vco_half), .i_base_clock_out(base),
        .o_crystal_level(xtal), .o_vco_level(vco), .o_oscillator_enable(osc_en),
        .o_base_edges(base_edges));

    // clock generation
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {24'h0, e}, {24'h0, d});
    endtask : rdc
    // poll one bandwidth bit under a bound
    task automatic wait_bw(input int bitn, input logic e);
        logic [7:0] d;
        for (int k = 0; k < 80; k++) begin
            rd(OFF_BW, d);
            if (d[bitn] === e) break;
            cyc(20);
        end
        chk("bandwidth bit", {31'h0, e}, {31'h0, d[bitn]});
    endtask : wait_bw
    // base rising edges over a window, one edge of slack
    task automatic base_rate(input int win, input int e, input string nm);
        int b0;
        b0 = base_edges;
        cyc(win);
        chk(nm, 32'h1, 32'((base_edges - b0 >= e - 1) && (base_edges - b0 <= e + 1)));
    endtask : base_rate
    task automatic do_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        cyc(10);
        i_rst <= 1'b0;
    endtask : do_reset

    // reset values, unmapped address, crystal-sourced base rate
    task automatic t_reset();
        rdc(OFF_CTRL, 8'h00, "ctrl");
        rdc(OFF_BW, 8'h00, "bw");
        rdc(OFF_PROG, RST_PROG, "prog");
        rdc(OFF_STATUS, 8'h00, "status");
        chk("track", 32'h0, {31'h0, trk});
        wr(3'h6, 8'hff);
        rdc(3'h6, 8'h00, "unmapped");
        base_rate(400, 10, "crystal base rate");
    endtask : t_reset
    // crystal output silent while enable is low
    task automatic t_osc_off();
        int seen;
        seen = 0;
        osc_req <= 1'b0;
        cyc(10);
        repeat (100) begin
            @(posedge i_clk);
            #1 if (xclk_out !== 1'b0 || amp_out !== 1'b0) seen++;
        end
        chk("crystal gated", 32'h0, seen);
        osc_req <= 1'b1;
        cyc(10);
        seen = 0;
        repeat (40) begin
            @(posedge i_clk);
            #1 seen += int'(amp_out !== ~xclk_out);
        end
        chk("amplifier inverse", 32'h0, seen);
    endtask : t_osc_off
    // centre of range follows l
    task automatic t_centre();
        for (int l = 1; l <= 15; l += 7) begin
            wr(OFF_PROG, {4'h2, 4'(l)});
            cyc(2);
            chk("centre", 32'(l) * 32'h004b_0000, centre);
        end
    endtask : t_centre
    // refusals, stasis during hand-over, vco-sourced base rate
    task automatic t_select();
        int b0;
        wr(OFF_PROG, 8'h24);
        wr(OFF_CTRL, 8'h10);
        rdc(OFF_CTRL, 8'h00, "vco while off");
        wr(OFF_CTRL, 8'h30);
        rdc(OFF_CTRL, 8'h00, "both at once");
        wr(OFF_CTRL, 8'h20);
        rdc(OFF_CTRL, 8'h20, "loop on");
        wr(OFF_CTRL, 8'h30);
        rdc(OFF_STATUS, 8'h04, "switching");
        b0 = base_edges;
        cyc(26);
        chk("base held", b0, base_edges);
        cyc(100);
        rdc(OFF_STATUS, 8'h02, "vco active");
        base_rate(400, 20, "vco base rate");
        wr(OFF_CTRL, 8'h10);
        rdc(OFF_CTRL, 8'h30, "off while selected");
        wr(OFF_CTRL, 8'h00);
        rdc(OFF_CTRL, 8'h30, "both off");
        wr(OFF_CTRL, 8'h20);
        cyc(150);
    endtask : t_select
    // manual mode bit drives the filter mode
    task automatic t_manual();
        wr(OFF_BW, 8'h00);
        cyc(2);
        chk("manual acquire", 32'h0, {31'h0, trk});
        rdc(OFF_BW, 8'h00, "manual bw");
        wr(OFF_BW, 8'h20);
        cyc(2);
        chk("manual track", 32'h1, {31'h0, trk});
        rdc(OFF_BW, 8'h20, "manual bw set");
    endtask : t_manual
    // automatic lock, interrupts on entry and exit, pump direction, zero l
    task automatic t_auto();
        int nu, nd, nb;
        {nu, nd, nb} = '0;
        do_reset();
        wr(OFF_PROG, 8'h24);
        wr(OFF_BW, 8'h80);
        wr(OFF_CTRL, 8'ha0);
        wait_bw(6, 1'b1);
        cyc(4);
        chk("irq on lock", 32'h1, {31'h0, irq});
        rdc(OFF_BW, 8'he0, "auto bw");
        wr(OFF_STATUS, 8'h01);
        cyc(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(OFF_CTRL, 8'hb0);
        cyc(150);
        rdc(OFF_STATUS, 8'h02, "vco base");
        vco_half = 8;
        repeat (400) begin
            @(posedge i_clk);
            #1 nu += int'(up === 1'b1);
            nd += int'(dn === 1'b1);
            nb += int'(up === 1'b1 && dn === 1'b1);
        end
        chk("pump up dominant", 32'h1, 32'(nu > nd));
        chk("pump both", 32'h0, nb);
        wait_bw(6, 1'b0);
        cyc(4);
        chk("irq on unlock", 32'h1, {31'h0, irq});
        chk("forced track", 32'h1, {31'h0, trk});
        wr(OFF_PROG, 8'h20);
        cyc(150);
        rdc(OFF_STATUS, 8'h01, "zero l forces crystal");
        chk("zero l loop off", 32'h0, {31'h0, trk});
        vco_half = 5;
    endtask : t_auto
    // divider zero behaves as one
    task automatic t_div0();
        do_reset();
        vco_half = 10;
        wr(OFF_PROG, 8'h01);
        wr(OFF_BW, 8'h80);
        wr(OFF_CTRL, 8'h20);
        wait_bw(6, 1'b1);
    endtask : t_div0

    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        {i_rst, i_wr, i_rd, osc_req, i_addr, i_wdata} = {4'h9, 3'h0, 8'h00};
        {vco_half, bad_count, n_compared, cycles} = {32'd5, 96'd0};
        do_reset();
        t_reset();
        t_osc_off();
        t_centre();
        t_select();
        t_manual();
        t_auto();
        t_div0();
        tally_and_finish();
    end
endmodule : pll_clock_generator_control_bench
